// >>> rtl/csd_decimator.sv
`default_nettype none
module csd_decimator
   import csd_pkg::*;
(
   input  wire logic               i_mclk,
   input  wire logic               i_resetn,
   input  wire logic               i_mod_clk,
   input  wire logic               i_mod_bit,
   input  wire logic               i_rate_wr,
   input  wire logic [RATE_W-1:0]  i_rate_word_bits,
   input  wire logic               i_res_ready,
   output logic [RATE_W-1:0]       o_rate_word,
   output logic                    o_chop,
   output logic [ACC_W-1:0]        o_res_data,
   output logic                    o_res_valid,
   output logic                    o_rdy_n,
   output logic                    o_overrun
);
   //==========================================================
   // declarations
   //==========================================================
   logic [SYNC_N-1:0]       clk_sync_ff;
   logic [SYNC_N-1:0]       bit_sync_ff;
   logic                    mod_lvl_ff;
   logic                    smp_en;
   logic [RATE_W-1:0]       rate_ff;
   logic                    restart;
   logic                    chop_ff;
   logic [DEC_CNT_W-1:0]    dec_cnt_ff;
   logic [DEC_CNT_W-1:0]    dec_len;
   logic                    dec_tick;
   logic [1:0]              ph_cnt_ff;
   logic signed [ACC_W-1:0] x_in;
   logic signed [ACC_W-1:0] i1_ff, i2_ff, i3_ff;
   logic signed [ACC_W-1:0] d1_ff, d2_ff, d3_ff;
   logic signed [ACC_W-1:0] c1, c2, c3;
   logic signed [ACC_W-1:0] conv_ff;
   logic                    conv_v_ff;
   logic signed [ACC_W-1:0] prev_ff;
   logic                    hist_ok_ff;
   logic signed [ACC_W:0]   sum2;
   logic [ACC_W-1:0]        pend_ff;
   logic                    pend_v_ff;
   logic [ACC_W-1:0]        head_ff, tail_ff;
   logic                    head_v_ff, tail_v_ff;
   logic                    pop, push, buf_ready;
   logic                    rdy_n_ff;
   logic                    ovr_ff;

   //==========================================================
   // pin synchronisers and modulator sample enable
   //==========================================================
   // three stages; a change counts once stages two and three agree
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         clk_sync_ff <= '0;
         bit_sync_ff <= '0;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], i_mod_clk};
         bit_sync_ff <= {bit_sync_ff[1:0], i_mod_bit};
      end
   end

   // agreed level of the modulator clock
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         mod_lvl_ff <= 1'b0;
      end else if (clk_sync_ff[1] == clk_sync_ff[2]) begin
         mod_lvl_ff <= clk_sync_ff[2];
      end
   end

   // one pulse per modulator sample at 32.768 kHz
   assign smp_en = (clk_sync_ff[1] == clk_sync_ff[2]) &&
                   clk_sync_ff[2] && !mod_lvl_ff;

   //==========================================================
   // rate word register
   //==========================================================
   // out of range writes are ignored, power-up value 69
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rate_ff <= RATE_RESET;
      end else if (i_rate_wr && i_rate_word_bits >= RATE_MIN &&
                   i_rate_word_bits <= RATE_MAX) begin
         rate_ff <= i_rate_word_bits;
      end
   end

   // any accepted write wipes filter state and history
   assign restart = i_rate_wr && i_rate_word_bits >= RATE_MIN &&
                    i_rate_word_bits <= RATE_MAX;

   //==========================================================
   // decimation counters
   //==========================================================
   // length is eight times the rate word
   assign dec_len  = {rate_ff, {DEC_MULT_SH{1'b0}}};
   assign dec_tick = smp_en && (dec_cnt_ff == dec_len - 1'b1);

   // sample counter within one sinc3 output period
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         dec_cnt_ff <= '0;
      end else if (restart) begin
         dec_cnt_ff <= '0;
      end else if (dec_tick) begin
         dec_cnt_ff <= '0;
      end else if (smp_en) begin
         dec_cnt_ff <= dec_cnt_ff + 1'b1;
      end
   end

   // three sinc3 periods form one conversion: 24 x word samples
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ph_cnt_ff <= '0;
      end else if (restart) begin
         ph_cnt_ff <= '0;
      end else if (dec_tick) begin
         ph_cnt_ff <= (ph_cnt_ff == DEC_PER_CONV - 1'b1) ? 2'h0
                      : ph_cnt_ff + 1'b1;
      end
   end

   //==========================================================
   // chop phase
   //==========================================================
   // flips after every conversion: period is two conversions
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         chop_ff <= 1'b0;
      end else if (restart) begin
         chop_ff <= 1'b0;
      end else if (dec_tick && ph_cnt_ff == DEC_PER_CONV - 1'b1) begin
         chop_ff <= ~chop_ff;
      end
   end

   //==========================================================
   // sinc3 integrators
   //==========================================================
   // output chop: stream xor phase, mapped to +1 or -1
   assign x_in = (bit_sync_ff[2] ^ chop_ff) ? ACC_W'(1)
                                             : -ACC_W'(1);

   // three cascaded accumulators at the modulator rate
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         i1_ff <= '0;
         i2_ff <= '0;
         i3_ff <= '0;
      end else if (restart) begin
         i1_ff <= '0;
         i2_ff <= '0;
         i3_ff <= '0;
      end else if (smp_en) begin
         i1_ff <= i1_ff + x_in;
         i2_ff <= i2_ff + i1_ff + x_in;
         i3_ff <= i3_ff + i2_ff + i1_ff + x_in;
      end
   end

   //==========================================================
   // sinc3 combs at the decimated rate
   //==========================================================
   // combs see the integrator values including the current sample
   assign c1 = (i3_ff + i2_ff + i1_ff + x_in) - d1_ff;
   assign c2 = c1 - d2_ff;
   assign c3 = c2 - d3_ff;

   // comb delays, cleared on restart
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         d1_ff <= '0;
         d2_ff <= '0;
         d3_ff <= '0;
      end else if (restart) begin
         d1_ff <= '0;
         d2_ff <= '0;
         d3_ff <= '0;
      end else if (dec_tick) begin
         d1_ff <= i3_ff + i2_ff + i1_ff + x_in;
         d2_ff <= c1;
         d3_ff <= c2;
      end
   end

   // last sinc3 output of a chop phase is its conversion
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         conv_ff   <= '0;
         conv_v_ff <= 1'b0;
      end else begin
         conv_v_ff <= 1'b0;
         if (!restart && dec_tick &&
             ph_cnt_ff == DEC_PER_CONV - 1'b1) begin
            conv_ff   <= c3;
            conv_v_ff <= 1'b1;
         end
      end
   end

   //==========================================================
   // two-tap running average
   //==========================================================
   // opposite offsets of neighbouring phases cancel
   assign sum2 = {conv_ff[ACC_W-1], conv_ff} +
                 {prev_ff[ACC_W-1], prev_ff};

   // first conversion after restart only primes history
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         prev_ff    <= '0;
         hist_ok_ff <= 1'b0;
      end else if (restart) begin
         hist_ok_ff <= 1'b0;
      end else if (conv_v_ff) begin
         prev_ff    <= conv_ff;
         hist_ok_ff <= 1'b1;
      end
   end

   // pending result waits here while the buffer is full
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pend_ff   <= '0;
         pend_v_ff <= 1'b0;
         ovr_ff    <= 1'b0;
      end else if (conv_v_ff && hist_ok_ff && !restart) begin
         pend_ff   <= sum2[ACC_W:1];
         pend_v_ff <= 1'b1;
         ovr_ff    <= ovr_ff | (pend_v_ff && !buf_ready);
      end else if (push) begin
         pend_v_ff <= 1'b0;
      end
   end

   //==========================================================
   // two-entry output buffer
   //==========================================================
   assign pop       = head_v_ff && i_res_ready;
   assign buf_ready = !tail_v_ff;
   assign push      = pend_v_ff && buf_ready;

   // head is the data register, tail catches a stalled word
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         head_ff   <= '0;
         head_v_ff <= 1'b0;
         tail_ff   <= '0;
         tail_v_ff <= 1'b0;
      end else begin
         if (pop) begin
            head_ff   <= tail_v_ff ? tail_ff : pend_ff;
            head_v_ff <= tail_v_ff || push;
            tail_v_ff <= tail_v_ff && push;
            tail_ff   <= pend_ff;
         end else if (push && !head_v_ff) begin
            head_ff   <= pend_ff;
            head_v_ff <= 1'b1;
         end else if (push) begin
            tail_ff   <= pend_ff;
            tail_v_ff <= 1'b1;
         end
      end
   end

   //==========================================================
   // data ready flag
   //==========================================================
   // high after a read or just before an update, low once data
   // sits in the data register
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdy_n_ff <= 1'b1;
      end else if (pop || (conv_v_ff && hist_ok_ff)) begin
         rdy_n_ff <= 1'b1;
      end else if (head_v_ff) begin
         rdy_n_ff <= 1'b0;
      end
   end

   //==========================================================
   // outputs
   //==========================================================
   assign o_rate_word = rate_ff;
   assign o_chop      = chop_ff;
   assign o_res_data  = head_ff;
   assign o_res_valid = head_v_ff;
   assign o_rdy_n     = rdy_n_ff;
   assign o_overrun   = ovr_ff;
endmodule : csd_decimator
`default_nettype wire

// >>> rtl/csd_pkg.sv
//==============================================================
// constants of the chopped sinc3 decimator
//==============================================================
// Operation
// - 32.768 kHz stream in, one result per 24xword samples
// - sinc3 decimates by eight times rate word
// - sinc3 cascaded with two-tap averaging stage
// - chop polarity toggles at output rate
// - decimator outputs alternate chop phase each conversion
// - result averages current and previous decimator output
// - first settled result after two conversion periods
// - input step fully shown in third output
// - rate word 13 to 255, resets to 69
// - each word step adds 24 modulator samples
// - rate word bits 7..0 select update rate
// - set bit means plus one, cleared means minus one
// - modulator bit xored with chop phase first
// - ready low on new result, high on read
`default_nettype none
package csd_pkg;
   // modulator sample rate in hertz
   localparam int unsigned MOD_SAMPLE_RATE_HZ = 32768;
   // rate word field, reset value and legal range
   localparam int          RATE_W       = 8;
   localparam logic [7:0]  RATE_RESET   = 8'h45;
   localparam logic [7:0]  RATE_MIN     = 8'h0D;
   localparam logic [7:0]  RATE_MAX     = 8'hFF;
   // decimation length is rate word shifted left by this
   localparam int          DEC_MULT_SH  = 3;
   localparam int          DEC_CNT_W    = 11;
   // sinc3 outputs per conversion (one chop phase)
   localparam logic [1:0]  DEC_PER_CONV = 2'h3;
   // modulator samples added per rate step
   localparam int          SAMPLES_PER_STEP = 24;
   // accumulator width: 3*log2(2040) plus sign and guard
   localparam int          ACC_W        = 36;
   // synchroniser depth for pin inputs
   localparam int          SYNC_N       = 3;
endpackage : csd_pkg
`default_nettype wire

// >>> sim/csd_decimator_properties.sv
`default_nettype none
module csd_checker
   import csd_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_resetn,
   input  wire logic              i_rate_wr,
   input  wire logic [RATE_W-1:0] i_rate_word_bits,
   input  wire logic              i_res_ready,
   input  wire logic [RATE_W-1:0] o_rate_word,
   input  wire logic              o_chop,
   input  wire logic [ACC_W-1:0]  o_res_data,
   input  wire logic              o_res_valid,
   input  wire logic              o_rdy_n,
   input  wire logic              o_overrun
);
   timeunit 1ns;
   timeprecision 1ps;
   // shortest chop phase: 312 samples of at least 8 clocks
   localparam int CHOP_MIN = 2496;
   logic        take;
   logic [11:0] chop_age_ff;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   assign take = i_rate_wr && (i_rate_word_bits >= RATE_MIN);
   sequence s_take;
      take;
   endsequence
   sequence s_pop;
      o_res_valid && i_res_ready;
   endsequence
   // clocks since the chop phase moved or the filter restarted
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         chop_age_ff <= '0;
      end else if ($changed(o_chop) || take) begin
         chop_age_ff <= '0;
      end else if (chop_age_ff != 12'hFFF) begin
         chop_age_ff <= chop_age_ff + 12'h1;
      end
   end
   //======
   // checks
   //======
   a_rate_taken: assert property (
      s_take |=> o_rate_word == $past(i_rate_word_bits))
      else $error("rate word not loaded");
   a_rate_refused: assert property (
      i_rate_wr && !take |=> $stable(o_rate_word))
      else $error("out of range rate word accepted");
   a_chop_cleared: assert property (
      s_take |=> !o_chop) else $error("chop not cleared by restart");
   a_chop_spacing: assert property (
      $changed(o_chop) && !$past(take) |-> chop_age_ff >= CHOP_MIN)
      else $error("chop phase too short");
   a_ready_falls: assert property (
      $rose(o_res_valid) && !i_res_ready |=> !o_rdy_n)
      else $error("ready not low after new result");
   a_pop_ready: assert property (
      s_pop |=> o_rdy_n) else $error("ready low after read");
   a_ready_data: assert property (
      !o_rdy_n |-> o_res_valid) else $error("ready low without data");
   a_head_hold: assert property (
      o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_data))
      else $error("unread result changed");
endmodule : csd_checker
`default_nettype wire

// >>> sim/csd_mod_model.sv
`default_nettype none
module csd_mod_model (
   input  wire logic i_mclk,
   input  wire logic i_chop,
   input  wire logic i_level,
   input  wire logic i_in_chop,
   output var logic  o_mod_clk,
   output var logic  o_mod_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] phase_ff;
   // free-running sample clock, ten clocks a sample
   initial begin
      phase_ff = 4'h0;
      o_mod_clk = 1'b0;
      o_mod_bit = 1'b0;
   end
   // bit moves only while the clock is low, clear of the sampling rise
   always @(posedge i_mclk) begin
      phase_ff <= (phase_ff == 4'h9) ? 4'h0 : phase_ff + 4'h1;
      if (phase_ff == 4'h0) begin
         o_mod_clk <= 1'b1;
      end
      if (phase_ff == 4'h5) begin
         o_mod_clk <= 1'b0;
      end
      // input chop follows the phase each clock of the low half, so a restart that
      // clears the phase never leaves a stale bit for the next sample
      if (phase_ff >= 4'h5) begin
         o_mod_bit <= i_level ^ (i_in_chop & i_chop);
      end
   end
endmodule : csd_mod_model
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb
   import csd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk, i_resetn, i_rate_wr, i_res_ready, level, in_chop;
   logic mod_clk, mod_bit, o_chop, o_res_valid, o_rdy_n, o_overrun;
   logic [RATE_W-1:0] i_rate_word_bits, o_rate_word;
   logic [ACC_W-1:0]  o_res_data, d;
   int failures, samples_checked, samples, n1, n2, k;
   csd_decimator u_csd_decimator (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_mod_clk(mod_clk),
      .i_mod_bit(mod_bit), .i_rate_wr(i_rate_wr),
      .i_rate_word_bits(i_rate_word_bits), .i_res_ready(i_res_ready),
      .o_rate_word(o_rate_word), .o_chop(o_chop), .o_res_data(o_res_data),
      .o_res_valid(o_res_valid), .o_rdy_n(o_rdy_n), .o_overrun(o_overrun));
   csd_mod_model u_csd_mod_model (
      .i_mclk(i_mclk), .i_chop(o_chop), .i_level(level),
      .i_in_chop(in_chop), .o_mod_clk(mod_clk), .o_mod_bit(mod_bit));
   // clock and modulator sample count
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   always @(posedge mod_clk) samples++;
   //======
   // helpers
   //======
   task automatic check(string name, logic [ACC_W-1:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic bound(int lim);
      if (k >= lim) begin
         failures++;
         tally_and_finish();
      end
   endtask : bound
   // write just after a sample fall, so no sample is in flight
   task automatic write_rate(logic [RATE_W-1:0] v);
      for (k = 0; k < 20 && mod_clk !== 1'b1; k++) @(negedge i_mclk);
      bound(20);
      for (k = 0; k < 20 && mod_clk !== 1'b0; k++) @(negedge i_mclk);
      bound(20);
      i_rate_wr = 1'b1;
      i_rate_word_bits = v;
      samples = 0;
      @(negedge i_mclk);
      i_rate_wr = 1'b0;
   endtask : write_rate
   // wait for a result, note sample count and data, then read it
   task automatic get_res(output int n);
      for (k = 0; k < 40000 && o_res_valid !== 1'b1; k++) @(negedge i_mclk);
      bound(40000);
      n = samples;
      d = o_res_data;
      i_res_ready = 1'b1;
      @(negedge i_mclk);
      i_res_ready = 1'b0;
      check("rdy_n after read", o_rdy_n, 1'b1);
   endtask : get_res
   //======
   // scenarios
   //======
   task automatic t_regs;
      check("reset rate", o_rate_word, 8'h45);
      write_rate(8'h0C);
      check("refused rate", o_rate_word, 8'h45);
      write_rate(8'hFF);
      check("top rate", o_rate_word, 8'hFF);
      $display("test regs done");
   endtask : t_regs
   task automatic t_conv(int sf);
      logic c;
      write_rate(RATE_W'(sf));
      check("chop on restart", o_chop, 1'b0);
      get_res(n1);
      c = o_chop;
      check("settle samples", ACC_W'(n1), ACC_W'(48 * sf));
      check("gain", d, ACC_W'(512 * sf * sf * sf));
      get_res(n2);
      check("period", ACC_W'(n2 - n1), ACC_W'(24 * sf));
      check("chop flips", o_chop, !c);
      $display("test conv %0d done", sf);
   endtask : t_conv
   task automatic t_offset;
      in_chop = 1'b0;
      write_rate(8'h0D);
      get_res(n1);
      check("offset removed", d, '0);
      in_chop = 1'b1;
      $display("test offset done");
   endtask : t_offset
   task automatic t_step;
      write_rate(8'h0D);
      get_res(n1);
      repeat (700) @(negedge i_mclk);
      level = 1'b0;
      repeat (3) get_res(n1);
      check("step third", d, -ACC_W'(512 * 2197));
      level = 1'b1;
      $display("test step done");
   endtask : t_step
   task automatic t_overrun;
      write_rate(8'h0D);
      for (k = 0; k < 40000 && samples < 1250; k++) @(negedge i_mclk);
      bound(40000);
      check("no overrun", o_overrun, 1'b0);
      for (k = 0; k < 40000 && samples < 1565; k++) @(negedge i_mclk);
      bound(40000);
      check("overrun", o_overrun, 1'b1);
      for (k = 0; k < 5 && o_res_valid === 1'b1; k++) begin
         i_res_ready = 1'b1;
         @(negedge i_mclk);
         i_res_ready = 1'b0;
         @(negedge i_mclk);
      end
      check("words held", ACC_W'(k), ACC_W'(3));
      check("drained rdy_n", o_rdy_n, 1'b1);
      $display("test overrun done");
   endtask : t_overrun
   // reset, then every scenario in turn
   initial begin
      i_resetn = 1'b0;
      i_rate_wr = 1'b0;
      i_rate_word_bits = 8'h45;
      i_res_ready = 1'b0;
      level = 1'b1;
      in_chop = 1'b1;
      repeat (10) @(negedge i_mclk);
      i_resetn = 1'b1;
      @(negedge i_mclk);
      t_regs();
      t_conv(13);
      t_conv(14);
      t_offset();
      t_step();
      t_overrun();
      tally_and_finish();
   end
endmodule : tb
bind csd_decimator csd_checker u_csd_checker (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_rate_wr(i_rate_wr),
   .i_rate_word_bits(i_rate_word_bits), .i_res_ready(i_res_ready),
   .o_rate_word(o_rate_word), .o_chop(o_chop), .o_res_data(o_res_data),
   .o_res_valid(o_res_valid), .o_rdy_n(o_rdy_n), .o_overrun(o_overrun));
`default_nettype wire
